// *** pkg/fprc_defs.vh ***
`ifndef FPRC_DEFS_VH
`define FPRC_DEFS_VH

// ****************************************
// Command opcodes
// ****************************************
`define FPRC_OP_WRITE_ENABLE_CMD 8'h06
`define FPRC_OP_WRDI 8'h04
`define FPRC_OP_SEC_WRITE 8'h2f
`define FPRC_OP_PROT_SEL 8'h68
`define FPRC_OP_BLK_LOCK 8'h36
`define FPRC_OP_BLK_UNLOCK 8'h39
`define FPRC_OP_BLK_READ 8'h3c
`define FPRC_OP_GANG_LOCK 8'h7e
`define FPRC_OP_GANG_UNLOCK 8'h98
`define FPRC_OP_FLAG_CLR 8'h30
`define FPRC_OP_RYBY_ON 8'h70
`define FPRC_OP_RYBY_OFF 8'h80
`define FPRC_OP_NOP 8'h00
`define FPRC_OP_RST_ARM 8'h66
`define FPRC_OP_RST 8'h99

// ****************************************
// Frame lengths in bits, and the bit count at the last opcode bit
// ****************************************
`define FPRC_BITS_CMD 6'd8
`define FPRC_BITS_ADDR 6'd32
`define FPRC_BITS_LAST_CMD 6'd7

// ****************************************
// Lock bit store
// ****************************************
`define FPRC_LOCK_AW 9
`define FPRC_LOCK_DEPTH 288
`define FPRC_LOCK_LAST 9'h11f
`define FPRC_BLK_BOTTOM 8'h00
`define FPRC_BLK_TOP 8'hff
`define FPRC_IDX_BOTTOM 5'h10
`define FPRC_IDX_TOP 5'h11
`define FPRC_BLK_COUNT 9'h100
`define FPRC_BP_ALL 4'h9

// ****************************************
// Timing
// ****************************************
`define FPRC_CLK_NS 4
`define FPRC_REC_SHORT_NS 1000
`define FPRC_REC_LONG_NS 4000
`define FPRC_REC_SHORT_CYC \
	((`FPRC_REC_SHORT_NS + `FPRC_CLK_NS - 1) / `FPRC_CLK_NS)
`define FPRC_REC_LONG_CYC \
	((`FPRC_REC_LONG_NS + `FPRC_CLK_NS - 1) / `FPRC_CLK_NS)

`endif

// *** design/fprc_lock_mem.v ***
`timescale 1ns/1ps
`include "fprc_defs.vh"

module fprc_lock_mem
(
	input wire mclk_i,
	input wire wr_en_i,
	input wire [`FPRC_LOCK_AW-1:0] wr_addr_i,
	input wire wr_data_i,
	input wire [`FPRC_LOCK_AW-1:0] rd_addr_a_i,
	input wire [`FPRC_LOCK_AW-1:0] rd_addr_b_i,
	output reg rd_data_a_o,
	output reg rd_data_b_o
);

	reg mem [0:`FPRC_LOCK_DEPTH-1];

	always @(posedge mclk_i)
	begin
		if (wr_en_i)
			mem[wr_addr_i] <= wr_data_i;
		rd_data_a_o <= mem[rd_addr_a_i];
		rd_data_b_o <= mem[rd_addr_b_i];
	end

endmodule // fprc_lock_mem

// *** design/fprc_cmd.v ***
`timescale 1ns/1ps
`include "fprc_defs.vh"

module fprc_cmd
(
	input wire mclk_i,
	input wire reset_n_i,
	input wire cs_n_i,
	input wire sclk_i,
	input wire si_i,
	input wire wp_n_i,
	output reg so_o,
	output reg so_oe_o,
	input wire nv_prot_sel_i,
	input wire nv_otp_lock_i,
	input wire [3:0] range_protect_bits_i,
	input wire status_write_disable_bit_i,
	input wire continuous_program_mode_i,
	input wire array_busy_i,
	input wire prog_fail_i,
	input wire erase_fail_i,
	input wire [23:0] array_addr_i,
	output reg array_prot_o,
	output reg range_bits_wr_ok_o,
	output reg protection_scheme_select_o,
	output reg otp_customer_lock_bit_o,
	output reg otp_update_ok_o,
	output reg prog_fail_o,
	output reg erase_fail_o,
	output reg wel_o,
	output reg reset_armed_o,
	output reg abort_o,
	output reg busy_o
);

	localparam integer REC_SHORT = `FPRC_REC_SHORT_CYC;
	localparam integer REC_LONG = `FPRC_REC_LONG_CYC;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	reg [1:0] cs_sy;
	reg [1:0] sck_sy;
	reg [1:0] si_sy;
	reg [1:0] wp_sy;
	reg sck_d;
	reg cs_d;

	always @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			cs_sy <= 2'b11;
			sck_sy <= 2'b00;
			si_sy <= 2'b00;
			wp_sy <= 2'b11;
			sck_d <= 1'b0;
			cs_d <= 1'b1;
		end
		else
		begin
			cs_sy <= {cs_sy[0], cs_n_i};
			sck_sy <= {sck_sy[0], sclk_i};
			si_sy <= {si_sy[0], si_i};
			wp_sy <= {wp_sy[0], wp_n_i};
			sck_d <= sck_sy[1];
			cs_d <= cs_sy[1];
		end
	end

	wire cs_high = cs_sy[1];
	wire wp_low = ~wp_sy[1];
	wire sck_rise = sck_sy[1] & ~sck_d;
	wire sck_fall = ~sck_sy[1] & sck_d;
	wire cs_rise = cs_sy[1] & ~cs_d;

	// ****************************************
	// Serial input shifter
	// ****************************************
	reg [31:0] sh;
	reg [5:0] cnt;
	reg [7:0] op_q;
	wire [7:0] op_byte = {sh[6:0], si_sy[1]};

	always @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			sh <= 32'h0000_0000;
			cnt <= 6'h00;
			op_q <= 8'h00;
		end
		else if (cs_high)
			cnt <= 6'h00;
		else if (sck_rise)
		begin
			if (cnt < `FPRC_BITS_ADDR)
				sh <= {sh[30:0], si_sy[1]};
			if (cnt != 6'h3f)
				cnt <= cnt + 6'h01;
			if (cnt == `FPRC_BITS_LAST_CMD)
				op_q <= op_byte;
		end
	end

	// Only frames that end on the exact length are executed
	wire one_byte = (cnt == `FPRC_BITS_CMD);
	wire four_byte = (cnt == `FPRC_BITS_ADDR);
	wire [7:0] op_run = four_byte ? sh[31:24] : sh[7:0];
	wire [23:0] addr_run = sh[23:0];

	// ****************************************
	// Lock bit index
	// ****************************************
	function [8:0] lock_idx;
		input [23:0] a;
		begin
			case (a[23:16])
			`FPRC_BLK_BOTTOM: lock_idx = {`FPRC_IDX_BOTTOM, a[15:12]};
			`FPRC_BLK_TOP: lock_idx = {`FPRC_IDX_TOP, a[15:12]};
			default: lock_idx = {1'b0, a[23:16]};
			endcase
		end
	endfunction

	// ****************************************
	// Lock store and sweep
	// ****************************************
	reg sweep_act;
	reg sweep_val;
	reg [8:0] sweep_idx;
	reg one_we;
	reg one_val;
	reg [8:0] one_idx;
	wire lock_rd_a;
	wire lock_rd_b;
	wire mem_we = sweep_act | one_we;
	wire [8:0] mem_waddr = sweep_act ? sweep_idx : one_idx;
	wire mem_wdata = sweep_act ? sweep_val : one_val;

	fprc_lock_mem u_lock_mem
	(
		.mclk_i(mclk_i),
		.wr_en_i(mem_we),
		.wr_addr_i(mem_waddr),
		.wr_data_i(mem_wdata),
		.rd_addr_a_i(lock_idx(addr_run)),
		.rd_addr_b_i(lock_idx(array_addr_i)),
		.rd_data_a_o(lock_rd_a),
		.rd_data_b_o(lock_rd_b)
	);

	// ****************************************
	// Command execution
	// ****************************************
	reg prot_sel;
	reg otp_lock;
	reg wel;
	reg arm;
	reg ryby_en;
	reg pfail;
	reg efail;
	reg [11:0] rec_cnt;
	wire idle = ~sweep_act & (rec_cnt == 12'h000);
	wire run = cs_rise & idle;
	wire run1 = run & one_byte;
	wire run4 = run & four_byte;
	wire blk_ok = wel & prot_sel;
	wire do_rst = run1 & arm & (op_run == `FPRC_OP_RST);
	wire do_clr = run1 & (op_run == `FPRC_OP_FLAG_CLR);

	always @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			prot_sel <= nv_prot_sel_i;
			otp_lock <= nv_otp_lock_i;
			wel <= 1'b0;
			arm <= 1'b0;
			ryby_en <= 1'b0;
			rec_cnt <= 12'h000;
			abort_o <= 1'b0;
			one_we <= 1'b0;
			one_val <= 1'b0;
			one_idx <= 9'h000;
			sweep_act <= 1'b1;
			sweep_val <= 1'b1;
			sweep_idx <= 9'h000;
		end
		else
		begin
			abort_o <= 1'b0;
			one_we <= 1'b0;
			if (rec_cnt != 12'h000)
				rec_cnt <= rec_cnt - 12'h001;
			if (sweep_act)
			begin
				sweep_idx <= sweep_idx + 9'h001;
				if (sweep_idx == `FPRC_LOCK_LAST)
					sweep_act <= 1'b0;
			end
			// Opcode byte decides whether a pending reset survives
			if (!cs_high && sck_rise && cnt == `FPRC_BITS_LAST_CMD &&
				arm && op_byte != `FPRC_OP_RST)
				arm <= 1'b0;
			if (run1)
			begin
				case (op_run)
				`FPRC_OP_WRITE_ENABLE_CMD: wel <= 1'b1;
				`FPRC_OP_WRDI: wel <= 1'b0;
				`FPRC_OP_SEC_WRITE: otp_lock <= 1'b1;
				`FPRC_OP_PROT_SEL: prot_sel <= 1'b1;
				`FPRC_OP_GANG_LOCK, `FPRC_OP_GANG_UNLOCK:
					if (blk_ok)
					begin
						sweep_act <= 1'b1;
						sweep_idx <= 9'h000;
						sweep_val <= (op_run == `FPRC_OP_GANG_LOCK);
						wel <= 1'b0;
					end
				`FPRC_OP_RYBY_ON:
					if (continuous_program_mode_i)
						ryby_en <= 1'b1;
				`FPRC_OP_RYBY_OFF: ryby_en <= 1'b0;
				`FPRC_OP_RST_ARM: arm <= 1'b1;
				default: ;
				endcase
			end
			if (run4 && blk_ok && (op_run == `FPRC_OP_BLK_LOCK ||
				op_run == `FPRC_OP_BLK_UNLOCK))
			begin
				one_we <= 1'b1;
				one_val <= (op_run == `FPRC_OP_BLK_LOCK);
				one_idx <= lock_idx(addr_run);
				wel <= 1'b0;
			end
			if (do_rst)
			begin
				arm <= 1'b0;
				wel <= 1'b0;
				ryby_en <= 1'b0;
				abort_o <= array_busy_i;
				rec_cnt <= array_busy_i ? REC_LONG[11:0] :
					REC_SHORT[11:0];
			end
			if (!continuous_program_mode_i)
				ryby_en <= 1'b0;
		end
	end

	// ****************************************
	// Fail flags
	// ****************************************
	always @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			pfail <= 1'b0;
			efail <= 1'b0;
		end
		else
		begin
			// New failure wins over a clear in the same cycle
			pfail <= (pfail & ~do_clr & ~do_rst) | prog_fail_i;
			efail <= (efail & ~do_clr & ~do_rst) | erase_fail_i;
		end
	end

	// ****************************************
	// Serial output
	// ****************************************
	wire rd_blk = ~cs_high & (cnt >= `FPRC_BITS_ADDR) &
		(op_q == `FPRC_OP_BLK_READ) & prot_sel & idle;

	always @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			so_o <= 1'b0;
			so_oe_o <= 1'b0;
		end
		else if (rd_blk)
		begin
			if (sck_fall)
			begin
				so_oe_o <= 1'b1;
				so_o <= lock_rd_a;
			end
		end
		else if (ryby_en && continuous_program_mode_i)
		begin
			so_oe_o <= 1'b1;
			so_o <= ~(array_busy_i | ~idle);
		end
		else
		begin
			so_oe_o <= 1'b0;
			so_o <= 1'b0;
		end
	end

	// ****************************************
	// Array protection query
	// ****************************************
	wire [8:0] bp_span = 9'h001 << (range_protect_bits_i - 4'h1);
	wire range_hit_now = (range_protect_bits_i >= `FPRC_BP_ALL) ||
		((range_protect_bits_i != 4'h0) &&
		({1'b0, array_addr_i[23:16]} >= (`FPRC_BLK_COUNT - bp_span)));
	reg range_hit;
	reg wp_low_d;

	always @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			range_hit <= 1'b0;
			wp_low_d <= 1'b0;
			array_prot_o <= 1'b1;
			range_bits_wr_ok_o <= 1'b1;
		end
		else
		begin
			range_hit <= range_hit_now;
			wp_low_d <= wp_low;
			// Scheme select picks the range bits alone, or the WP pin, lock bits and sweep together
			array_prot_o <= prot_sel ? (wp_low_d | lock_rd_b | sweep_act) :
				range_hit;
			range_bits_wr_ok_o <= ~(status_write_disable_bit_i & wp_low);
		end
	end

	// ****************************************
	// Status outputs
	// ****************************************
	always @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			protection_scheme_select_o <= 1'b0;
			otp_customer_lock_bit_o <= 1'b0;
			otp_update_ok_o <= 1'b0;
			prog_fail_o <= 1'b0;
			erase_fail_o <= 1'b0;
			wel_o <= 1'b0;
			reset_armed_o <= 1'b0;
			busy_o <= 1'b1;
		end
		else
		begin
			protection_scheme_select_o <= prot_sel;
			otp_customer_lock_bit_o <= otp_lock;
			otp_update_ok_o <= ~otp_lock;
			prog_fail_o <= pfail;
			erase_fail_o <= efail;
			wel_o <= wel;
			reset_armed_o <= arm;
			busy_o <= ~idle;
		end
	end

endmodule // fprc_cmd

// *** verification/fprc_cmd_chk.sv ***
`timescale 1ns/1ps

module fprc_cmd_chk
(
	input wire mclk_i,
	input wire reset_n_i,
	input wire wp_n_i,
	input wire status_write_disable_bit_i,
	input wire [3:0] range_protect_bits_i,
	input wire array_busy_i,
	input wire prog_fail_i,
	input wire erase_fail_i,
	input wire array_prot_o,
	input wire range_bits_wr_ok_o,
	input wire protection_scheme_select_o,
	input wire otp_customer_lock_bit_o,
	input wire otp_update_ok_o,
	input wire prog_fail_o,
	input wire erase_fail_o,
	input wire abort_o,
	input wire busy_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!reset_n_i);

	property p_otp_ok;
		$past(reset_n_i) |-> otp_update_ok_o != otp_customer_lock_bit_o;
	endproperty
	a_otp_ok: assert property (p_otp_ok)
		else $error("otp update allowed while locked");
	property p_sel_kept;
		protection_scheme_select_o |=> protection_scheme_select_o;
	endproperty
	a_sel_kept: assert property (p_sel_kept)
		else $error("protection select returned to zero");
	property p_rwok;
		(status_write_disable_bit_i && !wp_n_i)[*6] |-> !range_bits_wr_ok_o;
	endproperty
	a_rwok: assert property (p_rwok)
		else $error("range bits writable while guarded");
	property p_wp_all;
		(protection_scheme_select_o && !wp_n_i)[*6] |-> array_prot_o;
	endproperty
	a_wp_all: assert property (p_wp_all)
		else $error("array writable with pin low");
	property p_range_none;
		(!protection_scheme_select_o && range_protect_bits_i == 4'h0)[*6]
			|-> !array_prot_o;
	endproperty
	a_range_none: assert property (p_range_none)
		else $error("block locks act in range mode");
	property p_pfail;
		prog_fail_i |-> ##[1:2] prog_fail_o;
	endproperty
	a_pfail: assert property (p_pfail)
		else $error("program fail flag not set");
	property p_efail;
		erase_fail_i |-> ##[1:2] erase_fail_o;
	endproperty
	a_efail: assert property (p_efail)
		else $error("erase fail flag not set");
	property p_abort;
		abort_o |-> array_busy_i ##1 !abort_o ##[0:2] busy_o[*8];
	endproperty
	a_abort: assert property (p_abort)
		else $error("abort without busy recovery");
endmodule // fprc_cmd_chk

bind fprc_cmd fprc_cmd_chk i_chk (.*);

// *** verification/fprc_host.sv ***
`timescale 1ns/1ps

module fprc_host
(
	output logic cs_n_o,
	output logic sclk_o,
	output logic si_o,
	input wire logic so_i
);
	initial
	begin
		cs_n_o = 1'h1;
		sclk_o = 1'h0;
		si_o = 1'h0;
	end

	// One frame of the low n bits of d, MSB first; q takes so at rises
	task automatic xfer(input logic [39:0] d, input int n,
		output logic [7:0] q);
		cs_n_o <= 1'h0;
		q = 8'h00;
		for (int i = n - 1; i >= 0; i--)
		begin
			si_o <= d[i];
			#62.5 sclk_o <= 1'h1;
			q = {q[6:0], so_i};
			#62.5 sclk_o <= 1'h0;
		end
		#62.5 cs_n_o <= 1'h1;
		// Released input shows the inverse of the last bit
		si_o <= ~si_o;
		#100;
	endtask
endmodule // fprc_host

// *** verification/fprc_cmd_tb.sv ***
`timescale 1ns/1ps

module fprc_cmd_tb;
	logic mclk_i = 1'h0, reset_n_i = 1'h0, wp_n_i = 1'h1;
	logic nv_prot_sel_i = 1'h0, nv_otp_lock_i = 1'h0;
	logic status_write_disable_bit_i = 1'h0, array_busy_i = 1'h0;
	logic continuous_program_mode_i = 1'h0;
	logic prog_fail_i = 1'h0, erase_fail_i = 1'h0;
	logic [3:0] range_protect_bits_i = 4'h0;
	logic [23:0] array_addr_i = 24'h0;
	logic [7:0] q;
	wire cs_n_i, sclk_i, si_i, so_o, so_oe_o, array_prot_o, wel_o;
	wire range_bits_wr_ok_o, protection_scheme_select_o, busy_o;
	wire otp_customer_lock_bit_o, otp_update_ok_o, reset_armed_o;
	wire prog_fail_o, erase_fail_o, abort_o;
	int n_errors = 0, compares = 0, cyc = 0, t_ab = 0;

	fprc_cmd i_dut (.*);
	fprc_host i_host (.cs_n_o(cs_n_i), .sclk_o(sclk_i), .si_o(si_i),
		.so_i(so_o));

	always #2 mclk_i = ~mclk_i;
	always @(posedge mclk_i)
	begin
		cyc <= cyc + 1;
		if (abort_o === 1'h1)
			t_ab <= cyc;
		if (cyc == 60000)
		begin
			n_errors++;
			tally_and_finish;
		end
	end

	task automatic chk(input string nm, input logic [7:0] got, exp);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic idle;
		for (int k = 0; k < 2000 && busy_o !== 1'h0; k++)
			@(posedge mclk_i);
		chk("idle", busy_o, 0);
	endtask
	task automatic cmd(input logic [7:0] op);
		i_host.xfer(op, $bits(op), q);
	endtask
	task automatic lk(input logic [7:0] op, input logic [23:0] a);
		cmd(8'h06);
		i_host.xfer({op, a}, 32, q);
		idle;
	endtask
	task automatic rd(input logic [23:0] a);
		i_host.xfer({8'h3c, a, 8'h00}, 40, q);
	endtask
	task automatic pa(input logic [23:0] a, input logic e, input string nm);
		@(posedge mclk_i) array_addr_i <= a;
		repeat (6) @(posedge mclk_i);
		chk(nm, array_prot_o, e);
	endtask
	task automatic pulse;
		@(posedge mclk_i) {prog_fail_i, erase_fail_i} <= 2'h3;
		@(posedge mclk_i) {prog_fail_i, erase_fail_i} <= 2'h0;
		repeat (3) @(posedge mclk_i);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_range;
		pa(24'h120000, 0, "bp0");
		@(posedge mclk_i) range_protect_bits_i <= 4'h9;
		pa(24'h000000, 1, "bp9");
		@(posedge mclk_i) status_write_disable_bit_i <= 1'h1;
		wp_n_i <= 1'h0;
		repeat (6) @(posedge mclk_i);
		chk("rwok", range_bits_wr_ok_o, 0);
		rd(24'h120000);
		chk("rd off", q, 8'h00);
		@(posedge mclk_i) status_write_disable_bit_i <= 1'h0;
		wp_n_i <= 1'h1;
		range_protect_bits_i <= 4'h0;
		repeat (6) @(posedge mclk_i);
		chk("rwok on", range_bits_wr_ok_o, 1);
		$display("range test done");
	endtask
	task automatic t_status;
		cmd(8'h2f);
		chk("otp", otp_customer_lock_bit_o, 1);
		chk("otp ok", otp_update_ok_o, 0);
		pulse;
		chk("pf", prog_fail_o, 1);
		chk("ef", erase_fail_o, 1);
		i_host.xfer({8'h30, 1'h0}, 9, q);
		chk("pf 9b", prog_fail_o, 1);
		cmd(8'h30);
		chk("pf clr", prog_fail_o, 0);
		chk("ef clr", erase_fail_o, 0);
		$display("status test done");
	endtask
	task automatic t_lock;
		cmd(8'h68);
		idle;
		chk("sel", protection_scheme_select_o, 1);
		rd(24'h120000);
		chk("rd lk", q, 8'hff);
		i_host.xfer({8'h39, 24'h120000}, 32, q);
		pa(24'h120000, 1, "no wel");
		cmd(8'h06);
		chk("wel", wel_o, 1);
		i_host.xfer({8'h39, 24'h120000}, 32, q);
		idle;
		chk("wel clr", wel_o, 0);
		pa(24'h12ff00, 0, "unlk");
		rd(24'h12ffff);
		chk("rd unlk", q, 8'h00);
		lk(8'h39, 24'h001000);
		pa(24'h001fff, 0, "sec");
		pa(24'h002000, 1, "sec nb");
		@(posedge mclk_i) range_protect_bits_i <= 4'h9;
		pa(24'h120000, 0, "bp off");
		@(posedge mclk_i) wp_n_i <= 1'h0;
		pa(24'h120000, 1, "wp");
		@(posedge mclk_i) wp_n_i <= 1'h1;
		range_protect_bits_i <= 4'h0;
		lk(8'h36, 24'h120000);
		pa(24'h120000, 1, "relk");
		$display("lock test done");
	endtask
	task automatic t_gang;
		cmd(8'h06);
		cmd(8'h98);
		idle;
		pa(24'hff0000, 0, "gang u");
		cmd(8'h06);
		i_host.xfer(7'h3f, 7, q);
		idle;
		pa(24'h120000, 0, "gang 7b");
		cmd(8'h06);
		cmd(8'h7e);
		idle;
		pa(24'h120000, 1, "gang l");
		$display("gang test done");
	endtask
	task automatic t_reset;
		@(posedge mclk_i) continuous_program_mode_i <= 1'h1;
		cmd(8'h70);
		chk("ry oe", so_oe_o, 1);
		chk("ry", so_o, 1);
		@(posedge mclk_i) array_busy_i <= 1'h1;
		repeat (6) @(posedge mclk_i);
		chk("by", so_o, 0);
		cmd(8'h80);
		chk("ry off", so_oe_o, 0);
		cmd(8'h66);
		chk("arm", reset_armed_o, 1);
		cmd(8'h00);
		chk("nop", reset_armed_o, 0);
		cmd(8'h66);
		cmd(8'h30);
		cmd(8'h99);
		chk("disarm", busy_o, 0);
		pulse;
		cmd(8'h06);
		cmd(8'h66);
		cmd(8'h99);
		chk("rec", busy_o, 1);
		chk("rst wel", wel_o, 0);
		chk("rst pf", prog_fail_o, 0);
		idle;
		chk("rec len", (cyc - t_ab) inside {[995:1005]}, 1);
		chk("sel kept", protection_scheme_select_o, 1);
		@(posedge mclk_i) array_busy_i <= 1'h0;
		$display("reset test done");
	endtask
	task automatic t_por;
		lk(8'h39, 24'h120000);
		pa(24'h120000, 0, "por pre");
		cmd(8'h66);
		cmd(8'h99);
		repeat (200) @(posedge mclk_i);
		chk("rec s", busy_o, 1);
		repeat (60) @(posedge mclk_i);
		chk("rec s end", busy_o, 0);
		@(posedge mclk_i) reset_n_i <= 1'h0;
		nv_prot_sel_i <= 1'h1;
		nv_otp_lock_i <= 1'h1;
		repeat (4) @(posedge mclk_i);
		reset_n_i <= 1'h1;
		repeat (2) @(posedge mclk_i);
		idle;
		chk("por sel", protection_scheme_select_o, 1);
		chk("por otp", otp_customer_lock_bit_o, 1);
		pa(24'h120000, 1, "por lk");
		$display("power-on test done");
	endtask

	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		repeat (4) @(posedge mclk_i);
		reset_n_i <= 1'h1;
		repeat (2) @(posedge mclk_i);
		idle;
		t_range;
		t_status;
		t_lock;
		t_gang;
		t_reset;
		t_por;
		tally_and_finish;
	end
endmodule // fprc_cmd_tb
